// ---- rcd_cfg.svh ----
// offsets, field positions and reset values of the reference clock block
`ifndef RCD_CFG_SVH
`define RCD_CFG_SVH

// ************************************************************
// latch selects carried in the two low bits of a serial word
// ************************************************************
`define RCD_SEL_REF     2'h0
`define RCD_SEL_NDIV    2'h1
`define RCD_SEL_MOD     2'h2
`define RCD_SEL_FUNC    2'h3

// ************************************************************
// bus offsets (byte addresses)
// ************************************************************
`define RCD_OFF_REF     8'h00
`define RCD_OFF_NDIV    8'h04
`define RCD_OFF_MOD     8'h08
`define RCD_OFF_FUNC    8'h0c
`define RCD_OFF_SYNTH   8'h10
`define RCD_OFF_STAT    8'h14

// ************************************************************
// field positions
// ************************************************************
`define RCD_FEC_LSB     2
`define RCD_FEC_MSB     12
`define RCD_VA_LO_BIT   13
`define RCD_VA_HI_BIT   14
`define RCD_DIV_LSB     19
`define RCD_DIV_MSB     22
`define RCD_FRAC_LSB    2
`define RCD_FRAC_MSB    13
`define RCD_INT_LSB     14
`define RCD_INT_MSB     21
`define RCD_BUF_EN_BIT  4
`define RCD_OSC_DIS_BIT 5
`define RCD_BIAS_LSB    9
`define RCD_BIAS_MSB    12

// ************************************************************
// reset values: divide field 8 gives divide by 16, buffer on
// ************************************************************
`define RCD_REF_RST     32'h0040_0000
`define RCD_NDIV_RST    32'h0000_0001
`define RCD_MOD_RST     32'h0000_0002
`define RCD_FUNC_RST    32'h0000_0013
`define RCD_DIV_RST_K   4'h8

// ************************************************************
// bus responses
// ************************************************************
`define RCD_RESP_OKAY   2'h0
`define RCD_RESP_SLVERR 2'h2

`endif

// ---- rcd_pkg.sv ----
// types shared by the reference clock block
`include "rcd_cfg.svh"
package rcd_pkg;

	typedef logic [31:0] rcd_word_t;

	// one word handed over by the serial loader
	typedef struct packed {
		logic      vld;
		logic [1:0] sel;
		rcd_word_t word;
	} rcd_load_t;

	// power-up value of each latch
	function automatic rcd_word_t rcd_reg_rst(input logic [1:0] idx);
		rcd_word_t v;
		v = `RCD_FUNC_RST;
		case (idx)
			`RCD_SEL_REF:  v = `RCD_REF_RST;
			`RCD_SEL_NDIV: v = `RCD_NDIV_RST;
			`RCD_SEL_MOD:  v = `RCD_MOD_RST;
			default:       v = `RCD_FUNC_RST;
		endcase
		return v;
	endfunction : rcd_reg_rst

endpackage : rcd_pkg

// ---- rcd_ser_load.sv ----
// three-wire serial loader: shift MSB first, hand over on strobe rise
`timescale 1ns/1ps
module rcd_ser_load import rcd_pkg::*; (
	input  wire logic      clk,
	input  wire logic      rst,
	input  wire logic      clk_en,
	input  wire logic      clr,
	input  wire logic      sclk_pin,
	input  wire logic      sdata_pin,
	input  wire logic      strobe_pin,
	output rcd_load_t      load
);

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	logic [2:0] pin_in;
	logic [2:0] s1;
	logic [2:0] s2;
	logic [2:0] s3;
	logic [31:0] shift;

	assign pin_in = {strobe_pin, sdata_pin, sclk_pin};

	// two flops per pin, third only for edge detection
	generate
		for (genvar i = 0; i < 3; i++) begin : g_sync
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					s1[i] <= 1'b0;
					s2[i] <= 1'b0;
					s3[i] <= 1'b0;
				end else if (clk_en) begin
					s1[i] <= pin_in[i];
					s2[i] <= s1[i];
					s3[i] <= s2[i];
				end
			end
		end
	endgenerate

	wire sclk_rise   = s2[0] & ~s3[0];
	wire strobe_rise = s2[2] & ~s3[2];

	// ************************************************************
	// shift register and hand-over
	// ************************************************************
	// a strobe in the same cycle as a clock edge hands over the old word
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			shift <= 32'h0000_0000;
			load  <= '0;
		end else if (clk_en) begin
			if (clr) begin
				shift <= 32'h0000_0000;
				load  <= '0;
			end else begin
				if (sclk_rise) begin
					shift <= {shift[30:0], s2[1]};
				end
				load.vld  <= strobe_rise;
				load.sel  <= shift[1:0];
				load.word <= shift;
			end
		end
	end

endmodule : rcd_ser_load

// ---- rcd_clk_div.sv ----
// even divider with glitch-free ratio change
`timescale 1ns/1ps
`include "rcd_cfg.svh"
module rcd_clk_div (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       clk_en,
	input  wire logic       clr,
	input  wire logic       tick,
	input  wire logic [3:0] half,
	output logic            q
);

	// ************************************************************
	// half-period counter
	// ************************************************************
	logic [3:0] cnt;
	logic [3:0] k_cur;

	// a zero field would never toggle, so it runs as the fastest ratio
	wire [3:0] k_eff = (half == 4'h0) ? 4'h1 : half;
	wire       wrap  = tick && (cnt == k_cur - 4'h1);

	// new ratio is only taken at an output edge or on clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt   <= 4'h0;
			k_cur <= `RCD_DIV_RST_K;
			q     <= 1'b0;
		end else if (clk_en) begin
			if (clr) begin
				cnt   <= 4'h0;
				k_cur <= k_eff;
				q     <= 1'b0;
			end else if (wrap) begin
				cnt   <= 4'h0;
				q     <= ~q;
				k_cur <= k_eff;
			end else if (tick) begin
				cnt <= cnt + 4'h1;
			end
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	AST_DIV_TOGGLE: assert property (@(posedge clk) disable iff (rst)
		clk_en && !clr && wrap |=> q != $past(q))
		else $error("divider missed its toggle");
	AST_DIV_HOLD: assert property (@(posedge clk) disable iff (rst)
		clk_en && !clr && !wrap |=> $stable(q) && $stable(k_cur))
		else $error("divider output or ratio moved off an edge");
	AST_CNT_RANGE: assert property (@(posedge clk) disable iff (rst)
		cnt < k_cur)
		else $error("divider count out of range");
	COV_RATIO_CHANGE: cover property (@(posedge clk) disable iff (rst)
		clk_en && !clr && wrap && (k_eff != k_cur));

endmodule : rcd_clk_div

// ---- rcd_top.sv ----
// reference clock divider and frequency word control, AXI4-Lite slave
// Notes on behaviour
// - synth value is compare frequency times integer plus fraction over 4096
// - correction step is compare frequency over 32768 times correction word
// - correction word is two's complement; set top bit lowers frequency
// - divided output is reference over even 2..30, equal high and low
// - divide field sits in bits 22 down to 19 of reference latch
// - divide ratio is 16 after power-up until rewritten
// - output buffer driven only while function bit 4 high; resets high
// - oscillator runs while disable low; on after power-up; off chip disabled
// - with disable high, external square wave on reference pin is used
// - two varactor bits in reference latch drive varactor adjust outputs
// - chip enable low clears every latch; software reprograms afterwards
// - serial words MSB first; two low bits pick latch at strobe rise
//
// The AXI4-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "rcd_cfg.svh"
module rcd_top import rcd_pkg::*; (
	input  wire logic        CORE_CLK,
	input  wire logic        RST,
	input  wire logic        CLK_EN,
	input  wire logic        CHIP_EN,
	input  wire logic        SER_CLK,
	input  wire logic        SER_DATA,
	input  wire logic        LOAD_LATCH_STROBE,
	input  wire logic        REF_INPUT_PIN,
	input  wire logic [7:0]  AWADDR,
	input  wire logic        AWVALID,
	output logic             AWREADY,
	input  wire logic [31:0] WDATA,
	input  wire logic [3:0]  WSTRB,
	input  wire logic        WVALID,
	output logic             WREADY,
	output logic [1:0]       BRESP,
	output logic             BVALID,
	input  wire logic        BREADY,
	input  wire logic [7:0]  ARADDR,
	input  wire logic        ARVALID,
	output logic             ARREADY,
	output logic [31:0]      RDATA,
	output logic [1:0]       RRESP,
	output logic             RVALID,
	input  wire logic        RREADY,
	output logic             DIVIDED_REF_OUTPUT,
	output logic             OSC_RUN,
	output logic             REF_EXT_SEL,
	output logic             VARACTOR_ADJUST_LO,
	output logic             VARACTOR_ADJUST_HI,
	output logic [3:0]       OSC_BIAS_FIELD
);

	// ************************************************************
	// declarations
	// ************************************************************
	rcd_word_t  regs [4];
	rcd_load_t  ser_load;
	logic       chip_s1;
	logic       chip_en;
	logic       ref_s1;
	logic       ref_s2;
	logic       ref_s3;
	logic       div_q;
	logic [7:0] aw_addr;
	logic       aw_full;
	rcd_word_t  w_data;
	logic [3:0] w_strb;
	logic       w_full;
	logic [7:0] ar_addr;

	// ************************************************************
	// chip enable and reference pin synchronisers
	// ************************************************************
	// external reference gets a third flop so its edge can be found
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			chip_s1 <= 1'b0;
			chip_en <= 1'b0;
			ref_s1  <= 1'b0;
			ref_s2  <= 1'b0;
			ref_s3  <= 1'b0;
		end else if (CLK_EN) begin
			chip_s1 <= CHIP_EN;
			chip_en <= chip_s1;
			ref_s1  <= REF_INPUT_PIN;
			ref_s2  <= ref_s1;
			ref_s3  <= ref_s2;
		end
	end

	// ************************************************************
	// field decode
	// ************************************************************
	wire [3:0]  div_field = regs[`RCD_SEL_REF][`RCD_DIV_MSB:`RCD_DIV_LSB];
	wire [10:0] fec       = regs[`RCD_SEL_REF][`RCD_FEC_MSB:`RCD_FEC_LSB];
	wire        va_lo     = regs[`RCD_SEL_REF][`RCD_VA_LO_BIT];
	wire        va_hi     = regs[`RCD_SEL_REF][`RCD_VA_HI_BIT];
	wire [11:0] frac_division_word = regs[`RCD_SEL_NDIV][`RCD_FRAC_MSB:`RCD_FRAC_LSB];
	wire [7:0]  int_division = regs[`RCD_SEL_NDIV][`RCD_INT_MSB:`RCD_INT_LSB];
	wire        ref_buf_en = regs[`RCD_SEL_FUNC][`RCD_BUF_EN_BIT];
	wire        osc_dis    = regs[`RCD_SEL_FUNC][`RCD_OSC_DIS_BIT];
	wire [3:0]  bias       = regs[`RCD_SEL_FUNC][`RCD_BIAS_MSB:`RCD_BIAS_LSB];
	wire        correction_sign_bit = fec[10];

	// ************************************************************
	// synthesis word in steps of compare frequency over 2^15
	// ************************************************************
	// integer and 12-bit fraction scaled by 8 so the 2^15 step lines up
	wire [31:0] synth_base = {9'h000, int_division, frac_division_word, 3'h0};
	wire [31:0] fec_ext    = {{21{correction_sign_bit}}, fec};
	wire [31:0] synth_word = synth_base + fec_ext;

	// ************************************************************
	// reference tick select
	// ************************************************************
	// internal oscillator is the core clock; external one ticks per rising edge
	wire osc_on   = chip_en & ~osc_dis;
	wire ref_tick = chip_en & (osc_dis ? (ref_s2 & ~ref_s3) : 1'b1);

	rcd_clk_div u_div (
		.clk    (CORE_CLK),
		.rst    (RST),
		.clk_en (CLK_EN),
		.clr    (~chip_en),
		.tick   (ref_tick),
		.half   (div_field),
		.q      (div_q)
	);

	rcd_ser_load u_ser (
		.clk        (CORE_CLK),
		.rst        (RST),
		.clk_en     (CLK_EN),
		.clr        (~chip_en),
		.sclk_pin   (SER_CLK),
		.sdata_pin  (SER_DATA),
		.strobe_pin (LOAD_LATCH_STROBE),
		.load       (ser_load)
	);

	// ************************************************************
	// bus write decode
	// ************************************************************
	wire       aw_take = AWVALID & AWREADY;
	wire       w_take  = WVALID & WREADY;
	wire [1:0] wr_idx  = aw_addr[3:2];
	wire       wr_hit  = (aw_addr[7:4] == 4'h0) && (aw_addr[1:0] == 2'h0);
	// a serial hand-over in the same cycle goes first; the bus write waits
	wire       wr_do   = aw_full & w_full & ~BVALID & ~ser_load.vld;
	wire [31:0] strb_mask = {{8{w_strb[3]}}, {8{w_strb[2]}},
	                         {8{w_strb[1]}}, {8{w_strb[0]}}};
	wire [31:0] merged    = (regs[wr_idx] & ~strb_mask) | (w_data & strb_mask);
	wire [31:0] next_reg  = {merged[31:2], wr_idx};

	// ************************************************************
	// latches
	// ************************************************************
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			regs[`RCD_SEL_REF]  <= `RCD_REF_RST;
			regs[`RCD_SEL_NDIV] <= `RCD_NDIV_RST;
			regs[`RCD_SEL_MOD]  <= `RCD_MOD_RST;
			regs[`RCD_SEL_FUNC] <= `RCD_FUNC_RST;
		end else if (CLK_EN) begin
			if (!chip_en) begin
				for (int i = 0; i < 4; i++) begin
					regs[i] <= rcd_reg_rst(i[1:0]);
				end
			end else if (ser_load.vld) begin
				regs[ser_load.sel] <= ser_load.word;
			end else if (wr_do && wr_hit) begin
				regs[wr_idx] <= next_reg;
			end
		end
	end

	// ************************************************************
	// write channels: address and data taken in either order
	// ************************************************************
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			AWREADY <= 1'b1;
			WREADY  <= 1'b1;
			aw_full <= 1'b0;
			w_full  <= 1'b0;
			aw_addr <= 8'h00;
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
			BVALID  <= 1'b0;
			BRESP   <= `RCD_RESP_OKAY;
		end else if (CLK_EN) begin
			if (aw_take) begin
				aw_addr <= AWADDR;
				aw_full <= 1'b1;
				AWREADY <= 1'b0;
			end
			if (w_take) begin
				w_data <= WDATA;
				w_strb <= WSTRB;
				w_full <= 1'b1;
				WREADY <= 1'b0;
			end
			if (wr_do) begin
				BVALID <= 1'b1;
				BRESP  <= wr_hit ? `RCD_RESP_OKAY : `RCD_RESP_SLVERR;
			end else if (BVALID && BREADY) begin
				BVALID  <= 1'b0;
				aw_full <= 1'b0;
				w_full  <= 1'b0;
				AWREADY <= 1'b1;
				WREADY  <= 1'b1;
			end
		end
	end

	// ************************************************************
	// read decode
	// ************************************************************
	wire [31:0] stat_word = {28'h0000000, DIVIDED_REF_OUTPUT, REF_EXT_SEL,
	                         OSC_RUN, chip_en};
	wire rd_hit = (ar_addr == `RCD_OFF_REF) || (ar_addr == `RCD_OFF_NDIV) ||
	              (ar_addr == `RCD_OFF_MOD) || (ar_addr == `RCD_OFF_FUNC) ||
	              (ar_addr == `RCD_OFF_SYNTH) || (ar_addr == `RCD_OFF_STAT);
	wire [31:0] rd_mux =
		(ar_addr == `RCD_OFF_REF)   ? regs[`RCD_SEL_REF]  :
		(ar_addr == `RCD_OFF_NDIV)  ? regs[`RCD_SEL_NDIV] :
		(ar_addr == `RCD_OFF_MOD)   ? regs[`RCD_SEL_MOD]  :
		(ar_addr == `RCD_OFF_FUNC)  ? regs[`RCD_SEL_FUNC] :
		(ar_addr == `RCD_OFF_SYNTH) ? synth_word :
		(ar_addr == `RCD_OFF_STAT)  ? stat_word : 32'h0000_0000;

	// ************************************************************
	// read channel: address taken, data on the next edge
	// ************************************************************
	logic rd_pend;
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			ARREADY <= 1'b1;
			ar_addr <= 8'h00;
			rd_pend <= 1'b0;
			RVALID  <= 1'b0;
			RDATA   <= 32'h0000_0000;
			RRESP   <= `RCD_RESP_OKAY;
		end else if (CLK_EN) begin
			if (ARVALID && ARREADY) begin
				ar_addr <= ARADDR;
				ARREADY <= 1'b0;
				rd_pend <= 1'b1;
			end else if (rd_pend) begin
				rd_pend <= 1'b0;
				RVALID  <= 1'b1;
				RDATA   <= rd_mux;
				RRESP   <= rd_hit ? `RCD_RESP_OKAY : `RCD_RESP_SLVERR;
			end else if (RVALID && RREADY) begin
				RVALID  <= 1'b0;
				ARREADY <= 1'b1;
			end
		end
	end

	// ************************************************************
	// pin outputs, all registered
	// ************************************************************
	// buffer gating adds one core cycle of delay, same on both edges
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			DIVIDED_REF_OUTPUT <= 1'b0;
			OSC_RUN            <= 1'b0;
			REF_EXT_SEL        <= 1'b0;
			VARACTOR_ADJUST_LO <= 1'b0;
			VARACTOR_ADJUST_HI <= 1'b0;
			OSC_BIAS_FIELD     <= 4'h0;
		end else if (CLK_EN) begin
			DIVIDED_REF_OUTPUT <= div_q & ref_buf_en & chip_en;
			OSC_RUN            <= osc_on;
			REF_EXT_SEL        <= chip_en & osc_dis;
			VARACTOR_ADJUST_LO <= va_lo;
			VARACTOR_ADJUST_HI <= va_hi;
			OSC_BIAS_FIELD     <= bias;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST);

	AST_DIV_DEFAULT: assert property (
		CLK_EN && !chip_en |=> div_field == `RCD_DIV_RST_K)
		else $error("divide field not at power-up value");
	AST_BUF_DEFAULT: assert property (
		CLK_EN && !chip_en |=> ref_buf_en && !osc_dis)
		else $error("function latch not at power-up value");
	AST_OUT_GATED: assert property (
		CLK_EN && !ref_buf_en |=> !DIVIDED_REF_OUTPUT)
		else $error("divided output driven with buffer off");
	AST_OSC_OFF: assert property (
		CLK_EN && !(chip_en && !osc_dis) |=> !OSC_RUN)
		else $error("oscillator running while disabled");
	AST_EXT_REF: assert property (
		CLK_EN && chip_en && osc_dis && !(ref_s2 && !ref_s3) |-> !ref_tick)
		else $error("reference tick without external edge");
	AST_SIGN: assert property (
		correction_sign_bit |-> $signed(synth_word) < $signed(synth_base))
		else $error("negative correction did not lower word");
	AST_SYNTH_READ: assert property (
		CLK_EN && rd_pend && ar_addr == `RCD_OFF_SYNTH ##1 CLK_EN |->
		RDATA == ({9'h000, $past(int_division), $past(frac_division_word), 3'h0}
		          + {{21{$past(fec[10])}}, $past(fec)}))
		else $error("synthesis word read back wrong");
	AST_SER_LOAD: assert property (
		CLK_EN && chip_en && ser_load.vld |=> regs[$past(ser_load.sel)] ==
		$past(ser_load.word))
		else $error("serial word not latched");
	AST_BRESP_ORDER: assert property (
		aw_take && !w_full |=> !BVALID)
		else $error("write answered before data arrived");

	COV_SER_LOAD: cover property (CLK_EN && ser_load.vld && ser_load.sel == `RCD_SEL_REF);
	COV_BUS_WRITE: cover property (CLK_EN && wr_do && wr_hit);
	COV_EXT_REF: cover property (CLK_EN && REF_EXT_SEL && ref_tick);
	COV_BAD_READ: cover property (RVALID && RRESP == `RCD_RESP_SLVERR);

endmodule : rcd_top

// ---- rcd_partner.sv ----
// far-side model: serial register loader and external square-wave reference
`timescale 1ns/1ps
module rcd_partner (
	input  wire logic clk,
	input  wire logic ext_on,
	output logic      ser_clk,
	output logic      ser_data,
	output logic      strobe,
	output logic      ref_pin
);
	logic [1:0] ref_cnt;

	// pins idle low before the first frame
	initial begin
		ser_clk = 1'b0;
		ser_data = 1'b0;
		strobe = 1'b0;
		ref_pin = 1'b0;
		ref_cnt = 2'h0;
	end

	// ****************************************************
	// external reference, period of 8 core cycles
	// ****************************************************
	// halted while unused so no stray edges reach the divider
	always @(posedge clk) begin
		if (!ext_on) begin
			ref_cnt <= 2'h0;
			ref_pin <= 1'b0;
		end else begin
			ref_cnt <= ref_cnt + 2'h1;
			if (ref_cnt == 2'h3) ref_pin <= ~ref_pin;
		end
	end

	// ****************************************************
	// serial word: msb first, then strobe high
	// ****************************************************
	// each level held at least 3 core cycles so the synchronisers see it
	task automatic send(input logic [31:0] w);
		for (int i = 31; i >= 0; i--) begin
			@(posedge clk);
			ser_data <= w[i];
			repeat (3) @(posedge clk);
			ser_clk <= 1'b1;
			repeat (3) @(posedge clk);
			ser_clk <= 1'b0;
		end
		repeat (3) @(posedge clk);
		strobe <= 1'b1;
		repeat (4) @(posedge clk);
		strobe <= 1'b0;
		ser_data <= ~w[0]; // released line shows no stale bit
	endtask : send
endmodule : rcd_partner

// ---- testbench.sv ----
// self-checking bench for the reference clock divider block
`timescale 1ns/1ps
`include "rcd_cfg.svh"
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin failures++; \
	$display("ERROR %s expected %h seen %h", nm, ex, got); end end
module testbench import rcd_pkg::*;;
	typedef struct packed {
		logic [7:0] a;
		rcd_word_t  d;
		logic [3:0] s;
		rcd_word_t  e;
		logic [1:0] br;
		logic [1:0] rr;
	} rcd_row_t;

	logic clk = 1'b0, rst = 1'b1, clk_en = 1'b1, chip_en = 1'b1, ext_on = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hf;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	wire logic awready, wready, bvalid, arready, rvalid, dref, osc_run, ext_sel;
	wire logic va_lo, va_hi, sclk, sdat, stb, refp;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	wire logic [3:0] bias;
	int failures = 0, n_checks = 0, cyc = 0, hi, lo;
	logic [1:0] resp;
	logic [31:0] rd;

	// write, then read back: address, data, strobes, readback, responses
	rcd_row_t rows [6] = '{
		'{`RCD_OFF_REF, 32'h0048_6000, 4'hf, 32'h0048_6000, 2'h0, 2'h0},
		'{`RCD_OFF_NDIV, 32'h0000_8401, 4'hf, 32'h0000_8401, 2'h0, 2'h0},
		'{`RCD_OFF_MOD, 32'h0000_00a9, 4'hf, 32'h0000_00aa, 2'h0, 2'h0},
		'{`RCD_OFF_FUNC, 32'h0000_0613, 4'hf, 32'h0000_0613, 2'h0, 2'h0},
		'{`RCD_OFF_FUNC, 32'hffff_ff03, 4'h1, 32'h0000_0603, 2'h0, 2'h0},
		'{8'h18, 32'h1234_5678, 4'hf, 32'h0, `RCD_RESP_SLVERR, `RCD_RESP_SLVERR}};

	always #2 clk = ~clk;

	rcd_top dut_u (.CORE_CLK(clk), .RST(rst), .CLK_EN(clk_en), .CHIP_EN(chip_en),
		.SER_CLK(sclk), .SER_DATA(sdat), .LOAD_LATCH_STROBE(stb), .REF_INPUT_PIN(refp),
		.AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata),
		.WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
		.BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
		.RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
		.DIVIDED_REF_OUTPUT(dref), .OSC_RUN(osc_run), .REF_EXT_SEL(ext_sel),
		.VARACTOR_ADJUST_LO(va_lo), .VARACTOR_ADJUST_HI(va_hi), .OSC_BIAS_FIELD(bias));

	rcd_partner partner_u (.clk(clk), .ext_on(ext_on), .ser_clk(sclk), .ser_data(sdat),
		.strobe(stb), .ref_pin(refp));

	// ****************************************************
	// bus tasks
	// ****************************************************
	// address and data offered together, each dropped once taken
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		logic ta, tw;
		ta = 1'b0;
		tw = 1'b0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ta && tw)) begin
			@(posedge clk);
			if (!ta && awready) begin ta = 1'b1; awvalid <= 1'b0; end
			if (!tw && wready) begin tw = 1'b1; wvalid <= 1'b0; end
		end
		while (bvalid !== 1'b1) @(posedge clk);
		resp = bresp;
		bready <= 1'b0;
	endtask : axw

	task automatic axr(input logic [7:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1) @(posedge clk);
		rd = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask : axr

	// one full high and low phase of the divided output, in core cycles
	task automatic meas();
		while (dref === 1'b1) @(posedge clk);
		while (dref !== 1'b1) @(posedge clk);
		hi = 0;
		lo = 0;
		while (dref === 1'b1) begin hi++; @(posedge clk); end
		while (dref !== 1'b1) begin lo++; @(posedge clk); end
	endtask : meas

	task automatic give_verdict();
		if (failures == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : give_verdict

	// hang guard, far above the several hundred cycles the run needs
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures++;
			give_verdict();
		end
	end

	// ****************************************************
	// main sequence
	// ****************************************************
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		foreach (rows[i]) begin
			axw(rows[i].a, rows[i].d, rows[i].s);
			`CHK("bresp", rows[i].br, resp)
			axr(rows[i].a);
			`CHK("rdata", rows[i].e, rd)
			`CHK("rresp", rows[i].rr, resp)
		end
		`CHK("var_lo", 1'b1, va_lo)
		`CHK("var_hi", 1'b1, va_hi)
		`CHK("bias", 4'h3, bias)
		repeat (40) begin @(posedge clk); `CHK("gated", 1'b0, dref) end
		// status word: output low, internal oscillator, chip enabled
		axr(`RCD_OFF_STAT);
		`CHK("stat", 32'h0000_0003, rd)
		axw(`RCD_OFF_FUNC, 32'h0000_0613, 4'hf);
		meas();
		`CHK("high_k9", 9, hi)
		`CHK("low_k9", 9, lo)
		// correction of -36 on integer 2, fraction 0x100
		axw(`RCD_OFF_REF, 32'h0048_1f70, 4'hf);
		axr(`RCD_OFF_SYNTH);
		`CHK("synth", 32'h0001_07dc, rd)
		`CHK("var_off", 1'b0, va_hi)
		// widest ratio, then narrowest; no runt while switching to the widest
		axw(`RCD_OFF_REF, 32'h0078_0000, 4'hf);
		meas();
		`CHK("no_runt", 1'b1, hi >= 9 && lo >= 9)
		meas();
		`CHK("high_k15", 15, hi)
		`CHK("low_k15", 15, lo)
		axw(`RCD_OFF_REF, 32'h0008_0000, 4'hf);
		meas();
		meas();
		`CHK("high_k1", 1, hi)
		`CHK("low_k1", 1, lo)
		// serial load selects the external reference
		ext_on <= 1'b1;
		partner_u.send(32'h0000_0833);
		repeat (8) @(posedge clk);
		axr(`RCD_OFF_FUNC);
		`CHK("serial", 32'h0000_0833, rd)
		`CHK("ext_sel", 1'b1, ext_sel)
		`CHK("osc_off", 1'b0, osc_run)
		`CHK("bias4", 4'h4, bias)
		meas();
		meas();
		`CHK("ext_high", 8, hi)
		`CHK("ext_low", 8, lo)
		// chip disable wipes the latches
		chip_en <= 1'b0;
		repeat (5) @(posedge clk);
		`CHK("osc_down", 1'b0, osc_run)
		`CHK("out_down", 1'b0, dref)
		ext_on <= 1'b0;
		chip_en <= 1'b1;
		repeat (5) @(posedge clk);
		`CHK("osc_up", 1'b1, osc_run)
		axr(`RCD_OFF_REF);
		`CHK("ref_rst", `RCD_REF_RST, rd)
		axr(`RCD_OFF_FUNC);
		`CHK("func_rst", `RCD_FUNC_RST, rd)
		meas();
		meas();
		`CHK("high_k8", 8, hi)
		`CHK("low_k8", 8, lo)
		// mid-run reset must drop a written ratio back to its power-up value
		axw(`RCD_OFF_REF, 32'h0078_0000, 4'hf);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		`CHK("rst_osc", 1'b1, osc_run)
		axr(`RCD_OFF_REF);
		`CHK("rst_ref", `RCD_REF_RST, rd)
		give_verdict();
	end
endmodule : testbench
